//--- rtl/pgb_map.vh
/*
 * Constants of the pixel gain and black level stage: register offsets,
 * field positions, reset values, arithmetic constants and sequencing counts.
 * Assumes it is included by bare name into the design files that need it.
 */
`ifndef PGB_MAP_VH
`define PGB_MAP_VH

// Register byte offsets on the APB slave.
`define PGB_ADDR_CONFIG 8'h00
`define PGB_ADDR_GAIN_SEL 8'h04
`define PGB_ADDR_GAIN_RAW 8'h08
`define PGB_ADDR_PED_SEL 8'h0C
`define PGB_ADDR_PED_RAW 8'h10
`define PGB_ADDR_STATUS 8'h14
`define PGB_ADDR_GAIN_FACTOR 8'h18
`define PGB_ADDR_SAT_COUNT 8'h1C

// Field positions in the configuration register.
`define PGB_CFG_VARIANT_LSB 0
`define PGB_CFG_DEPTH12_BIT 2
`define PGB_CFG_VBIN_BIT 3

// Field positions in the status register.
`define PGB_STAT_BUSY_BIT 0
`define PGB_STAT_GAIN_REJ_BIT 1
`define PGB_STAT_PED_REJ_BIT 2
`define PGB_STAT_PENDING_BIT 3

// Product variants and channel selector codes.
`define PGB_VAR_STD 2'h0
`define PGB_VAR_B 2'h1
`define PGB_VAR_C 2'h2
`define PGB_SEL_ALL 2'h0

// Reset values.
`define PGB_RST_GAIN_RAW 10'h0C0
`define PGB_RST_PED_RAW 10'h000
`define PGB_RST_GAIN_Q16 24'h010000

// Gain arithmetic: pole 658, band split 512, log2 slopes and offsets in Q16.
`define PGB_GAIN_POLE 11'h292
`define PGB_GAIN_BAND_SPLIT 10'h200
`define PGB_STD_EXP_SLOPE 9'h181
`define PGB_C_EXP_SLOPE 9'h187
`define PGB_C_EXP_BIAS 19'h01B07
`define PGB_B_GAIN_MAX 10'h016
`define PGB_B_GAIN_DIV 22'h000006

// Pedestal limits per variant.
`define PGB_PED_MAX_STD 10'h0FF
`define PGB_PED_MAX_B 10'h040
`define PGB_PED_MAX_C 10'h3FF

// Pixel full scale per depth and divider iteration count.
`define PGB_FULL_12 21'h000FFF
`define PGB_FULL_8 21'h0000FF
`define PGB_DIV_STEPS 6'h28

`endif

//--- rtl/pgb_exp2_rom.v
/*
 * Fractional power-of-two table: 2^(addr/32) in Q16, read through a register.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pgb_exp2_rom (
   input wire sys_clk_i,
   input wire reset_i,
   input wire [4:0] addr_i,
   output reg [16:0] data_o
);

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         data_o <= 17'h10000;
      end else begin
         case (addr_i)
            5'h00: data_o <= 17'h10000;
            5'h01: data_o <= 17'h1059B;
            5'h02: data_o <= 17'h10B56;
            5'h03: data_o <= 17'h11130;
            5'h04: data_o <= 17'h1172C;
            5'h05: data_o <= 17'h11D48;
            5'h06: data_o <= 17'h12388;
            5'h07: data_o <= 17'h129EA;
            5'h08: data_o <= 17'h13070;
            5'h09: data_o <= 17'h1371A;
            5'h0A: data_o <= 17'h13DEA;
            5'h0B: data_o <= 17'h144E0;
            5'h0C: data_o <= 17'h14BFE;
            5'h0D: data_o <= 17'h15343;
            5'h0E: data_o <= 17'h15AB0;
            5'h0F: data_o <= 17'h16248;
            5'h10: data_o <= 17'h16A0A;
            5'h11: data_o <= 17'h171F7;
            5'h12: data_o <= 17'h17A11;
            5'h13: data_o <= 17'h18259;
            5'h14: data_o <= 17'h18ACE;
            5'h15: data_o <= 17'h19373;
            5'h16: data_o <= 17'h19C49;
            5'h17: data_o <= 17'h1A550;
            5'h18: data_o <= 17'h1AE8A;
            5'h19: data_o <= 17'h1B7F7;
            5'h1A: data_o <= 17'h1C19A;
            5'h1B: data_o <= 17'h1CB72;
            5'h1C: data_o <= 17'h1D582;
            5'h1D: data_o <= 17'h1DFC9;
            5'h1E: data_o <= 17'h1EA4B;
            5'h1F: data_o <= 17'h1F507;
            default: data_o <= 17'h10000;
         endcase
      end
   end

endmodule // pgb_exp2_rom

`default_nettype wire

//--- rtl/pgb_pair_buffer.v
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pgb_pair_buffer #(
   parameter WIDTH = 12
) (
   input wire sys_clk_i,
   input wire reset_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   assign in_ready_o = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o = rd_ptr ? slot1 : slot0;

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            if (wr_ptr) begin
               slot1 <= in_data_i;
            end else begin
               slot0 <= in_data_i;
            end
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push & ~pop) begin
            count <= count + 2'h1;
         end else if (pop & ~push) begin
            count <= count - 2'h1;
         end
      end
   end

endmodule // pgb_pair_buffer

`default_nettype wire

//--- rtl/pixel_gain_black_level_offset.v
/*
 * Pixel amplification and black level offset stage with an APB register file.
 * Assumes one 100 MHz clock, an asynchronous active-high reset, pixels from
 * logic on the same clock and an APB master that keeps the usual protocol.
 */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pgb_map.vh"

// Functional notes
// - Standard variant, setting below 512: gain dB is 20log10((658+s)/(658-s)) minus the floor.
// - Standard variant, setting 512 and up: gain dB is 0.0354 times s minus the floor.
// - The floor is the logarithmic term at the minimum setting, so the minimum gives 0 dB.
// - Variant C: gain dB is 0.0359 times s minus 5.385 over the whole range.
// - Variant B accepts amplification settings 0 to 22 only.
// - Variant B: gain dB is 20log10(1 + s/6).
// - Raising the pedestal adds a larger positive offset to pixels, lowering it a smaller one; the offset is never negative.
// - Standard variant, 8-bit depth: 16 pedestal steps move the output by one code.
// - Standard variant, 12-bit depth: 1 pedestal step moves the output by one code.
// - Variant B: 4 pedestal steps move the output by one code in any format.
// - Variant C: 64 steps per code in 8-bit formats and 4 steps per code in 12-bit ones.
// - Pedestal spans 0-255 standard, 0-64 variant B and 0-1023 variant C.
// - Standard upper gain limit is 1023 at 8-bit and 511 at 12-bit; the lower limit follows binning.
module pixel_gain_black_level_offset #(
   parameter [9:0] STD_GAIN_MIN = 10'h0C0,
   parameter [9:0] STD_GAIN_MIN_VBIN = 10'h06E,
   parameter [9:0] STD_GAIN_MAX_8 = 10'h3FF,
   parameter [9:0] STD_GAIN_MAX_12 = 10'h1FF,
   parameter [9:0] C_GAIN_MIN = 10'h096,
   parameter [9:0] C_GAIN_MIN_VBIN = 10'h000,
   parameter [9:0] C_GAIN_MAX_8 = 10'h352,
   parameter [9:0] C_GAIN_MAX_12 = 10'h190
) (
   input wire sys_clk_i,
   input wire reset_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire pix_valid_i,
   input wire [11:0] pix_data_i,
   output wire pix_ready_o,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [11:0] out_data_o
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_EXP = 2'h1;
   localparam [1:0] ST_LOAD = 2'h2;
   localparam [1:0] ST_DIV = 2'h3;

   // Lowest accepted amplification setting of the current configuration.
   function [9:0] gain_min_f;
      input [1:0] variant;
      input vbin;
      begin
         case (variant)
            `PGB_VAR_B: gain_min_f = 10'h000;
            `PGB_VAR_C: gain_min_f = vbin ? C_GAIN_MIN_VBIN : C_GAIN_MIN;
            default: gain_min_f = vbin ? STD_GAIN_MIN_VBIN : STD_GAIN_MIN;
         endcase
      end
   endfunction

   function [9:0] gain_max_f;
      input [1:0] variant;
      input depth12;
      begin
         case (variant)
            `PGB_VAR_B: gain_max_f = `PGB_B_GAIN_MAX;
            `PGB_VAR_C: gain_max_f = depth12 ? C_GAIN_MAX_12 : C_GAIN_MAX_8;
            default: gain_max_f = depth12 ? STD_GAIN_MAX_12 : STD_GAIN_MAX_8;
         endcase
      end
   endfunction

   function [9:0] ped_max_f;
      input [1:0] variant;
      begin
         case (variant)
            `PGB_VAR_B: ped_max_f = `PGB_PED_MAX_B;
            `PGB_VAR_C: ped_max_f = `PGB_PED_MAX_C;
            default: ped_max_f = `PGB_PED_MAX_STD;
         endcase
      end
   endfunction

   // Right shift that turns pedestal steps into output codes.
   function [2:0] ped_shift_f;
      input [1:0] variant;
      input depth12;
      begin
         case (variant)
            `PGB_VAR_B: ped_shift_f = 3'h2;
            `PGB_VAR_C: ped_shift_f = depth12 ? 3'h2 : 3'h6;
            default: ped_shift_f = depth12 ? 3'h0 : 3'h4;
         endcase
      end
   endfunction

   reg [1:0] cfg_variant;
   reg cfg_depth12;
   reg cfg_vbin;
   reg [1:0] gain_sel;
   reg [9:0] gain_raw;
   reg [1:0] ped_sel;
   reg [9:0] ped_raw;
   reg gain_rej;
   reg ped_rej;
   reg addr_bad;
   reg [23:0] gain_q;
   reg [31:0] sat_count;
   reg recalc_pending;
   reg [1:0] state;
   reg [9:0] calc_s;
   reg [9:0] calc_min;
   reg [1:0] calc_var;
   reg [39:0] div_quo;
   reg [21:0] div_rem;
   reg [21:0] div_den;
   reg [5:0] div_cnt;
   reg s1_valid;
   reg [35:0] s1_prod;
   reg s2_valid;
   reg [11:0] s2_data;
   reg s2_sat;
   reg [39:0] next_num;
   reg [21:0] next_den;
   reg [31:0] next_rdata;

   wire apb_setup = psel_i & ~penable_i;
   wire apb_wr = psel_i & penable_i & pwrite_i;
   wire wdata_high_zero = (pwdata_i[31:10] == 22'h000000);
   wire [9:0] wdata_set = pwdata_i[9:0];
   wire [9:0] cur_gain_min = gain_min_f(cfg_variant, cfg_vbin);
   wire [9:0] cur_gain_max = gain_max_f(cfg_variant, cfg_depth12);
   wire gain_ok = (gain_sel == `PGB_SEL_ALL) & wdata_high_zero & (wdata_set >= cur_gain_min)
      & (wdata_set <= cur_gain_max);
   wire ped_ok = (ped_sel == `PGB_SEL_ALL) & wdata_high_zero
      & (wdata_set <= ped_max_f(cfg_variant));
   wire wr_cfg = apb_wr & (paddr_i == `PGB_ADDR_CONFIG);
   wire wr_gain = apb_wr & (paddr_i == `PGB_ADDR_GAIN_RAW);
   wire wr_ped = apb_wr & (paddr_i == `PGB_ADDR_PED_RAW);

   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & addr_bad;

   // Register file: writes land in the access phase.
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_variant <= `PGB_VAR_STD;
         cfg_depth12 <= 1'b0;
         cfg_vbin <= 1'b0;
         gain_sel <= `PGB_SEL_ALL;
         gain_raw <= `PGB_RST_GAIN_RAW;
         ped_sel <= `PGB_SEL_ALL;
         ped_raw <= `PGB_RST_PED_RAW;
         gain_rej <= 1'b0;
         ped_rej <= 1'b0;
      end else begin
         if (wr_cfg) begin
            cfg_variant <= pwdata_i[`PGB_CFG_VARIANT_LSB+1:`PGB_CFG_VARIANT_LSB];
            cfg_depth12 <= pwdata_i[`PGB_CFG_DEPTH12_BIT];
            cfg_vbin <= pwdata_i[`PGB_CFG_VBIN_BIT];
         end
         if (apb_wr & (paddr_i == `PGB_ADDR_GAIN_SEL)) begin
            gain_sel <= pwdata_i[1:0];
         end
         if (apb_wr & (paddr_i == `PGB_ADDR_PED_SEL)) begin
            ped_sel <= pwdata_i[1:0];
         end
         if (wr_gain) begin
            if (gain_ok) begin
               gain_raw <= wdata_set;
            end
            gain_rej <= ~gain_ok;
         end
         if (wr_ped) begin
            if (ped_ok) begin
               ped_raw <= wdata_set;
            end
            ped_rej <= ~ped_ok;
         end
      end
   end

   // Read data and the unmapped flag are captured in the setup phase.
   always @* begin
      next_rdata = 32'h00000000;
      case (paddr_i)
         `PGB_ADDR_CONFIG: next_rdata = {28'h0000000, cfg_vbin, cfg_depth12, cfg_variant};
         `PGB_ADDR_GAIN_SEL: next_rdata = {30'h00000000, gain_sel};
         `PGB_ADDR_GAIN_RAW: next_rdata = {22'h000000, gain_raw};
         `PGB_ADDR_PED_SEL: next_rdata = {30'h00000000, ped_sel};
         `PGB_ADDR_PED_RAW: next_rdata = {22'h000000, ped_raw};
         `PGB_ADDR_STATUS: next_rdata = {28'h0000000, recalc_pending, ped_rej, gain_rej,
            (state != ST_IDLE)};
         `PGB_ADDR_GAIN_FACTOR: next_rdata = {8'h00, gain_q};
         `PGB_ADDR_SAT_COUNT: next_rdata = sat_count;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prdata_o <= 32'h00000000;
         addr_bad <= 1'b0;
      end else if (apb_setup) begin
         prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
         addr_bad <= (paddr_i[1:0] != 2'h0) | (paddr_i > `PGB_ADDR_SAT_COUNT);
      end
   end

   // Gain factor sequencer: exponent lookup, operand set-up, long division.
   wire [18:0] exp_std = calc_s * `PGB_STD_EXP_SLOPE;
   wire [18:0] exp_c = calc_s * `PGB_C_EXP_SLOPE + `PGB_C_EXP_BIAS;
   wire [18:0] exp_sel = (calc_var == `PGB_VAR_C) ? exp_c : exp_std;
   wire [16:0] rom_q;
   wire [23:0] exp_val = {7'h00, rom_q} << exp_sel[18:16];
   wire [10:0] pole_plus_s = `PGB_GAIN_POLE + {1'b0, calc_s};
   wire [10:0] pole_minus_s = `PGB_GAIN_POLE - {1'b0, calc_s};
   wire [10:0] pole_plus_m = `PGB_GAIN_POLE + {1'b0, calc_min};
   wire [10:0] pole_minus_m = `PGB_GAIN_POLE - {1'b0, calc_min};
   wire [21:0] lo_num = pole_plus_s * pole_minus_m;
   wire [21:0] lo_den = pole_minus_s * pole_plus_m;
   wire [34:0] hi_num = exp_val * pole_minus_m;
   wire [10:0] b_num = {1'b0, calc_s} + 11'h006;
   wire [22:0] div_shift = {div_rem, div_quo[39]};
   wire [23:0] div_trial = {1'b0, div_shift} - {2'h0, div_den};
   wire div_fit = ~div_trial[23];

   pgb_exp2_rom u_exp2_rom (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .addr_i(exp_sel[15:11]),
      .data_o(rom_q)
   );

   always @* begin
      next_num = 40'h0000000000;
      next_den = 22'h000001;
      case (calc_var)
         `PGB_VAR_B: begin
            next_num = {13'h0000, b_num, 16'h0000};
            next_den = `PGB_B_GAIN_DIV;
         end
         `PGB_VAR_C: begin
            next_num = {17'h00000, exp_val[23:1]};
            next_den = 22'h000001;
         end
         default: begin
            if (calc_s < `PGB_GAIN_BAND_SPLIT) begin
               next_num = {2'h0, lo_num, 16'h0000};
               next_den = lo_den;
            end else begin
               next_num = {5'h00, hi_num};
               next_den = {11'h000, pole_plus_m};
            end
         end
      endcase
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         recalc_pending <= 1'b0;
         calc_s <= `PGB_RST_GAIN_RAW;
         calc_min <= `PGB_RST_GAIN_RAW;
         calc_var <= `PGB_VAR_STD;
         div_quo <= 40'h0000000000;
         div_rem <= 22'h000000;
         div_den <= 22'h000001;
         div_cnt <= 6'h00;
         gain_q <= `PGB_RST_GAIN_Q16;
      end else begin
         if (wr_cfg | (wr_gain & gain_ok)) begin
            recalc_pending <= 1'b1;
         end else if (state == ST_IDLE) begin
            recalc_pending <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (recalc_pending) begin
                  calc_s <= gain_raw;
                  calc_min <= cur_gain_min;
                  calc_var <= cfg_variant;
                  state <= ST_EXP;
               end
            end
            ST_EXP: begin
               state <= ST_LOAD;
            end
            ST_LOAD: begin
               div_quo <= next_num;
               div_den <= next_den;
               div_rem <= 22'h000000;
               div_cnt <= `PGB_DIV_STEPS;
               state <= ST_DIV;
            end
            ST_DIV: begin
               if (div_cnt == 6'h00) begin
                  gain_q <= (div_quo[39:24] != 16'h0000) ? 24'hFFFFFF : div_quo[23:0];
                  state <= ST_IDLE;
               end else begin
                  div_rem <= div_fit ? div_trial[21:0] : div_shift[21:0];
                  div_quo <= {div_quo[38:0], div_fit};
                  div_cnt <= div_cnt - 6'h01;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Pixel path: multiply, then depth reduction, pedestal and clamp.
   wire adv;
   wire [19:0] lin = s1_prod[35:16];
   wire [19:0] scaled = cfg_depth12 ? lin : {4'h0, lin[19:4]};
   wire [9:0] ped_codes = ped_raw >> ped_shift_f(cfg_variant, cfg_depth12);
   wire [20:0] with_ped = {1'b0, scaled} + {11'h000, ped_codes};
   wire [20:0] full = cfg_depth12 ? `PGB_FULL_12 : `PGB_FULL_8;
   wire over = (with_ped > full);

   assign pix_ready_o = adv;

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_valid <= 1'b0;
         s1_prod <= 36'h000000000;
         s2_valid <= 1'b0;
         s2_data <= 12'h000;
         s2_sat <= 1'b0;
         sat_count <= 32'h00000000;
      end else begin
         if (adv) begin
            s1_valid <= pix_valid_i;
            s1_prod <= pix_data_i * gain_q;
            s2_valid <= s1_valid;
            s2_data <= over ? full[11:0] : with_ped[11:0];
            s2_sat <= s1_valid & over;
            if (s2_valid & s2_sat) begin
               sat_count <= sat_count + 32'h00000001;
            end
         end
         if (apb_wr & (paddr_i == `PGB_ADDR_SAT_COUNT)) begin
            sat_count <= {31'h00000000, adv & s2_valid & s2_sat};
         end
      end
   end

   pgb_pair_buffer #(
      .WIDTH(12)
   ) u_out_buffer (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(s2_valid),
      .in_ready_o(adv),
      .in_data_i(s2_data),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_data_o(out_data_o)
   );

endmodule // pixel_gain_black_level_offset

`default_nettype wire

//--- test/pgb_checker.sv
/* Concurrent checks on the ports of the pixel gain stage.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pgb_checker (
   input wire sys_clk_i,
   input wire reset_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire pix_valid_i,
   input wire pix_ready_o,
   input wire out_valid_o,
   input wire out_ready_i,
   input wire [11:0] out_data_o
);
   logic depth12;
   wire acc = psel_i && penable_i;
   wire bad = acc && paddr_i > 8'h1C;
   // Follows the depth bit of the last configuration write.
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) depth12 <= 1'h0;
      else if (acc && pwrite_i && paddr_i == 8'h00) depth12 <= pwdata_i[2];
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_take; pix_valid_i && pix_ready_o && out_ready_i && !out_valid_o; endsequence
   sequence s_emerge; ##[1:3] out_valid_o; endsequence
   property p_latency; s_take |-> s_emerge; endproperty
   property p_ready; pready_o; endproperty
   property p_err_access; pslverr_o |-> acc; endproperty
   property p_err_unmapped; bad |-> pslverr_o && (pwrite_i || prdata_o == 32'h0); endproperty
   property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o); endproperty
   property p_full; !pix_ready_o |-> out_valid_o; endproperty
   property p_sat8; out_valid_o && !depth12 |-> out_data_o[11:8] == 4'h0; endproperty
   property p_quiet; $fell(reset_i) |-> !out_valid_o && pix_ready_o; endproperty
   a_latency: assert property (p_latency) else $error("pixel did not emerge in time");
   a_ready: assert property (p_ready) else $error("pready low");
   a_err_access: assert property (p_err_access) else $error("pslverr outside access");
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   a_hold: assert property (p_hold) else $error("output changed while stalled");
   a_full: assert property (p_full) else $error("input refused with empty output");
   a_sat8: assert property (p_sat8) else $error("8-bit pixel over full scale");
   a_quiet: assert property (p_quiet) else $error("stream not idle after reset");
endmodule // pgb_checker
`default_nettype wire

//--- test/pgb_pixel_sink.sv
/* Receiver of the output pixel stream; it stalls on request.
   Assumes the clock and reset of the stage. */
`timescale 1ns/1ps
`default_nettype none
module pgb_pixel_sink (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic stall_i,
   input wire logic valid_i,
   input wire logic [11:0] data_i,
   output logic ready_o,
   output logic [31:0] got_o,
   output logic [11:0] last_o
);
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ready_o <= 1'h0;
         got_o <= 32'h0;
         last_o <= 12'h000;
      end else begin
         ready_o <= !stall_i;
         if (valid_i && ready_o) begin
            got_o <= got_o + 32'h1;
            last_o <= data_i;
         end
      end
   end
endmodule // pgb_pixel_sink
`default_nettype wire

//--- test/pixel_gain_black_level_offset_bench.sv
/* Register and pixel tests of the gain and black level stage.
   Assumes the stage's register map and the pixel sink model. */
`timescale 1ns/1ps
`default_nettype none
module pixel_gain_black_level_offset_bench;
   logic sys_clk_i = 1'h0, reset_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic pix_valid_i = 1'h0, stall = 1'h0, out_ready_i, pix_ready_o, out_valid_o;
   logic pready_o, pslverr_o;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd, got;
   logic [11:0] pix_data_i = 12'h000, out_data_o, last;
   int n_errors = 0, checks_done = 0, sent, base, i;
   pixel_gain_black_level_offset u_pixel_gain_black_level_offset (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
      .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
      .out_data_o(out_data_o));
   pgb_pixel_sink u_pgb_pixel_sink (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .stall_i(stall),
      .valid_i(out_valid_o), .data_i(out_data_o), .ready_o(out_ready_i), .got_o(got),
      .last_o(last));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'h1;
      do @(posedge sys_clk_i); while (pready_o !== 1'h1);
      rd = prdata_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check("register", rd, exp);
   endtask
   task px(input logic [11:0] d, input logic [31:0] exp);
      base = got;
      @(posedge sys_clk_i);
      pix_valid_i <= 1'h1;
      pix_data_i <= d;
      do @(posedge sys_clk_i); while (pix_ready_o !== 1'h1);
      pix_valid_i <= 1'h0;
      for (i = 0; i < 50 && got == base; i++) @(posedge sys_clk_i);
      check("arrived", got - base, 32'h1);
      check("pixel", {20'h0, last}, exp);
   endtask
   task ped_case(input logic [3:0] cfg, input logic [9:0] ped, input logic [11:0] d,
                 input logic [11:0] exp);
      wr(8'h00, {28'h0, cfg});
      wr(8'h0C, 32'h0);
      wr(8'h10, {22'h0, ped});
      px(d, {20'h0, exp});
   endtask
   task settle;
      for (i = 0; i < 100; i++) begin
         apb(1'h0, 8'h14, 32'h0);
         if (rd[0] === 1'h0 && rd[3] === 1'h0) break;
      end
      check("idle", rd & 32'h9, 32'h0);
   endtask
   task gain_case(input logic [3:0] cfg, input logic [9:0] raw, input real db);
      real e;
      wr(8'h00, {28'h0, cfg});
      wr(8'h04, 32'h0);
      wr(8'h08, {22'h0, raw});
      settle;
      apb(1'h0, 8'h18, 32'h0);
      e = 65536.0 * $pow(10.0, db / 20.0);
      check("gain", {31'h0, rd > e * 0.97 && rd < e * 1.03}, 32'h1);
   endtask
   initial begin
      #400000;
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      rchk(8'h18, 32'h00010000);
      rchk(8'h08, 32'h000000C0);
      rchk(8'h10, 32'h0);
      rchk(8'h20, 32'h0);
      $display("reset values done");
      ped_case(4'h4, 10'h0FF, 12'hFFF, 12'hFFF);
      ped_case(4'h0, 10'h0FF, 12'hFFF, 12'h0FF);
      rchk(8'h1C, 32'h2);
      ped_case(4'h0, 10'h0FF, 12'h000, 12'h00F);
      ped_case(4'h0, 10'h010, 12'h000, 12'h001);
      ped_case(4'h4, 10'h0FF, 12'h000, 12'h0FF);
      ped_case(4'h4, 10'h001, 12'h000, 12'h001);
      ped_case(4'h5, 10'h040, 12'h000, 12'h010);
      ped_case(4'h1, 10'h004, 12'h000, 12'h001);
      ped_case(4'h2, 10'h3FF, 12'h000, 12'h00F);
      ped_case(4'h6, 10'h004, 12'h000, 12'h001);
      $display("pedestal done");
      wr(8'h00, 32'h1);
      wr(8'h10, 32'h40);
      wr(8'h10, 32'h41);
      rchk(8'h10, 32'h40);
      settle;
      rchk(8'h14, 32'h4);
      wr(8'h0C, 32'h1);
      wr(8'h10, 32'h20);
      rchk(8'h10, 32'h40);
      wr(8'h0C, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h16);
      wr(8'h08, 32'h17);
      rchk(8'h08, 32'h16);
      settle;
      rchk(8'h14, 32'h6);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h5);
      rchk(8'h08, 32'h16);
      wr(8'h00, 32'h4);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h200);
      rchk(8'h08, 32'h16);
      wr(8'h08, 32'h1FF);
      rchk(8'h08, 32'h1FF);
      $display("refusals done");
      gain_case(4'h0, 10'h1F4, 20.0 * $log10(1158.0 / 158.0) - 20.0 * $log10(850.0 / 466.0));
      gain_case(4'h0, 10'h200, 0.0354 * 512.0 - 20.0 * $log10(850.0 / 466.0));
      gain_case(4'h8, 10'h06E, 0.0);
      gain_case(4'h2, 10'h352, 0.0359 * 850.0 - 5.385);
      gain_case(4'h1, 10'h012, 20.0 * $log10(4.0));
      $display("gain done");
      stall <= 1'h1;
      sent = 0;
      base = got;
      pix_valid_i <= 1'h1;
      for (i = 0; i < 10; i++) begin
         @(posedge sys_clk_i);
         if (pix_ready_o === 1'h1) sent++;
      end
      pix_valid_i <= 1'h0;
      check("refused", {31'h0, pix_ready_o}, 32'h0);
      stall <= 1'h0;
      for (i = 0; i < 50 && got - base != sent; i++) @(posedge sys_clk_i);
      check("drained", got - base, sent);
      $display("buffer done");
      print_verdict;
   end
endmodule // pixel_gain_black_level_offset_bench
bind pixel_gain_black_level_offset pgb_checker u_pgb_checker (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
   .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o));
`default_nettype wire
